// ===== hdl/gate_driver_control_regs.sv
/*
 * Control register bank of a three-phase gate driver: four 11-bit
 * configuration registers, decoded settings for the driver, sense and
 * amplifier blocks, and the sleep sequence with regulator power-down delay.
 * Assumes a register access port already framed by the serial link logic,
 * synchronous to SYS_CLK at 25 MHz.
 */
`timescale 1ns/100ps
`default_nettype none
`include "gdc_params.svh"

module gate_driver_control_regs #(
    parameter int SLEEP_DELAY_LONG_CYCLES = `SLP_D3_US * `CLK_MHZ,
    parameter int WD_PERIOD0_CYCLES = `WD_P0_MS * `CLK_MHZ * 1000,
    parameter int WD_PERIOD1_CYCLES = `WD_P1_MS * `CLK_MHZ * 1000,
    parameter int WD_PERIOD2_CYCLES = `WD_P2_MS * `CLK_MHZ * 1000,
    parameter int WD_PERIOD3_CYCLES = `WD_P3_MS * `CLK_MHZ * 1000
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // register access from the serial link
    input wire logic REG_WR_EN,
    input wire logic REG_RD_EN,
    input wire logic [`ADDR_W-1:0] REG_ADDR,
    input wire logic [`DATA_W-1:0] REG_WR_DATA,
    output logic [`DATA_W-1:0] REG_RD_DATA,
    output logic REG_RD_VALID,
    // commutation and drain sense settings
    output logic ACTIVE_FREEWHEEL,
    output logic [1:0] INPUT_MODE,
    output logic [7:0] DEAD_TIME_CYCLES,
    output logic [7:0] DRAIN_SENSE_BLANK_CYCLES,
    output logic [7:0] DRAIN_SENSE_FILTER_CYCLES,
    // protection and watchdog settings
    output logic OVERHEAT_SHUTDOWN_ENABLE,
    output logic SUPPLY_LOW2_FAULT_DISABLE,
    output logic DRIVER_FAULT_DISABLE,
    output logic SHUNT_OVERCURRENT_DISABLE,
    output logic PUMP_LOW_THRESHOLD_SELECT,
    output logic WATCHDOG_ENABLE,
    output logic [`WD_CNT_W-1:0] WATCHDOG_PERIOD_CYCLES,
    output logic FAULT_CLEAR,
    // current amplifier settings
    output logic AMP_OUTPUT_CLAMP_ENABLE,
    output logic [2:0] AMP_OFFSET_CALIBRATE,
    output logic [7:0] AMP_BLANK_CYCLES,
    output logic [6:0] AMP1_GAIN_VV,
    output logic [6:0] AMP2_GAIN_VV,
    output logic [6:0] AMP3_GAIN_VV,
    // regulator settings and sleep state
    output logic [2:0] REF_SCALE_K,
    output logic REGULATOR_LOW_FAULT_DISABLE,
    output logic [6:0] REGULATOR_LOW_SETPOINT_PCT,
    output logic SLEEP_ACTIVE,
    output logic REGULATOR_OFF
);

    // ======================================================
    // address decode
    logic wr_gate;
    logic wr_op;
    logic wr_amp;
    logic wr_regu;
    logic sleep_entry;
    logic wake_req;
    logic [`DATA_W-1:0] gate_reg;
    logic [`DATA_W-1:0] op_reg;
    logic [`DATA_W-1:0] amp_reg;
    logic [`DATA_W-1:0] regu_reg;
    gdc_pkg::sleep_state_t state_reg;
    gdc_pkg::sleep_state_t state_next;
    logic [`SLP_CNT_W-1:0] cnt_reg;
    logic [`SLP_CNT_W-1:0] cnt_next;
    logic [`SLP_CNT_W-1:0] delay_load;
    logic fw_cause;

    // write strobes per register
    assign wr_gate = REG_WR_EN && (REG_ADDR == `ADDR_GATE);
    assign wr_op = REG_WR_EN && (REG_ADDR == `ADDR_OP);
    assign wr_amp = REG_WR_EN && (REG_ADDR == `ADDR_AMP);
    assign wr_regu = REG_WR_EN && (REG_ADDR == `ADDR_REG);

    // sleep request and wake request from operation register writes
    assign sleep_entry = wr_op && REG_WR_DATA[`OP_SLEEP_BIT];
    assign wake_req = wr_op && !REG_WR_DATA[`OP_SLEEP_BIT]
        && (state_reg != gdc_pkg::ST_AWAKE);

    // ======================================================
    // register storage: every register returns to default on sleep entry
    config_field_reg #(.WIDTH(`DATA_W), .DEFAULT(`GATE_DEFAULT)) u_gate (
        .clk(SYS_CLK),
        .rst(RST),
        .load_default(sleep_entry),
        .wr_en(wr_gate),
        .wr_data(REG_WR_DATA),
        .value(gate_reg)
    );

    config_field_reg #(.WIDTH(`DATA_W), .DEFAULT(`OP_DEFAULT)) u_op (
        .clk(SYS_CLK),
        .rst(RST),
        .load_default(sleep_entry),
        .wr_en(wr_op),
        .wr_data(REG_WR_DATA),
        .value(op_reg)
    );

    config_field_reg #(.WIDTH(`DATA_W), .DEFAULT(`AMP_DEFAULT)) u_amp (
        .clk(SYS_CLK),
        .rst(RST),
        .load_default(sleep_entry),
        .wr_en(wr_amp),
        .wr_data(REG_WR_DATA),
        .value(amp_reg)
    );

    config_field_reg #(.WIDTH(`DATA_W), .DEFAULT(`REG_DEFAULT)) u_regu (
        .clk(SYS_CLK),
        .rst(RST),
        .load_default(sleep_entry),
        .wr_en(wr_regu),
        .wr_data(REG_WR_DATA),
        .value(regu_reg)
    );

    // ======================================================
    // register read: registered data, unmapped addresses read zero
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            REG_RD_DATA <= '0;
            REG_RD_VALID <= 1'b0;
        end else begin
            REG_RD_VALID <= REG_RD_EN;
            if (REG_RD_EN) begin
                unique case (REG_ADDR)
                    `ADDR_GATE: REG_RD_DATA <= gate_reg;
                    `ADDR_OP: REG_RD_DATA <= op_reg;
                    `ADDR_AMP: REG_RD_DATA <= amp_reg;
                    `ADDR_REG: REG_RD_DATA <= regu_reg;
                    default: REG_RD_DATA <= '0;
                endcase
            end
        end
    end

    // ======================================================
    // fault clear pulse on each write of a one to the clear bit
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            FAULT_CLEAR <= 1'b0;
        end else begin
            FAULT_CLEAR <= wr_op && REG_WR_DATA[`OP_CLEAR_BIT];
        end
    end

    // ======================================================
    // power-down delay taken from the regulator register before it resets
    always_comb begin
        unique case (regu_reg[`REG_DLY_HI:`REG_DLY_LO])
            2'h0: delay_load = `SLP_CNT_W'(`CYC_CEIL(`SLP_D0_NS));
            2'h1: delay_load = `SLP_CNT_W'(`CYC_CEIL(`SLP_D1_NS));
            2'h2: delay_load = `SLP_CNT_W'(`CYC_CEIL(`SLP_D2_NS));
            2'h3: delay_load = `SLP_CNT_W'(SLEEP_DELAY_LONG_CYCLES);
        endcase
    end

    // sleep sequencer: wait the delay, then power the regulator down
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        unique case (state_reg)
            gdc_pkg::ST_AWAKE: begin
                if (sleep_entry) begin
                    state_next = gdc_pkg::ST_DELAY;
                    cnt_next = delay_load;
                end
            end
            gdc_pkg::ST_DELAY: begin
                if (sleep_entry) begin
                    cnt_next = delay_load;
                end else if (wake_req) begin
                    state_next = gdc_pkg::ST_AWAKE;
                end else if (cnt_reg == '0) begin
                    state_next = gdc_pkg::ST_OFF;
                end else begin
                    cnt_next = cnt_reg - `SLP_CNT_W'(1);
                end
            end
            gdc_pkg::ST_OFF: begin
                if (wake_req) begin
                    state_next = gdc_pkg::ST_AWAKE;
                end
            end
            default: begin
                state_next = gdc_pkg::ST_AWAKE;
            end
        endcase
    end

    // sequencer state and its output flops
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            state_reg <= gdc_pkg::ST_AWAKE;
            cnt_reg <= '0;
            SLEEP_ACTIVE <= 1'b0;
            REGULATOR_OFF <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            SLEEP_ACTIVE <= (state_next != gdc_pkg::ST_AWAKE);
            REGULATOR_OFF <= (state_next == gdc_pkg::ST_OFF);
        end
    end

    // ======================================================
    // commutation and drain sense decode
    assign fw_cause = gate_reg[`GATE_FW_BIT]
        && (gate_reg[`GATE_MODE_HI:`GATE_MODE_LO] == gdc_pkg::MODE_SINGLE);

    always_ff @(posedge SYS_CLK) begin
        ACTIVE_FREEWHEEL <= fw_cause;
        unique case (gate_reg[`GATE_MODE_HI:`GATE_MODE_LO])
            2'h1: INPUT_MODE <= gdc_pkg::MODE_THREE;
            2'h2: INPUT_MODE <= gdc_pkg::MODE_SINGLE;
            default: INPUT_MODE <= gdc_pkg::MODE_SIX;
        endcase
        unique case (gate_reg[`GATE_DT_HI:`GATE_DT_LO])
            3'h0: DEAD_TIME_CYCLES <= 8'(`CYC_CEIL(`DT0_NS));
            3'h1: DEAD_TIME_CYCLES <= 8'(`CYC_CEIL(`DT1_NS));
            3'h2: DEAD_TIME_CYCLES <= 8'(`CYC_CEIL(`DT2_NS));
            3'h3: DEAD_TIME_CYCLES <= 8'(`CYC_CEIL(`DT3_NS));
            3'h4: DEAD_TIME_CYCLES <= 8'(`CYC_CEIL(`DT4_NS));
            3'h5: DEAD_TIME_CYCLES <= 8'(`CYC_CEIL(`DT5_NS));
            3'h6: DEAD_TIME_CYCLES <= 8'(`CYC_CEIL(`DT6_NS));
            3'h7: DEAD_TIME_CYCLES <= 8'(`CYC_CEIL(`DT7_NS));
        endcase
        DRAIN_SENSE_BLANK_CYCLES <= sense_cycles(gate_reg[`GATE_BLANK_HI:`GATE_BLANK_LO]);
        DRAIN_SENSE_FILTER_CYCLES <= sense_cycles(gate_reg[`GATE_FILT_HI:`GATE_FILT_LO]);
    end

    // shared figures of the blanking and filter fields
    function automatic logic [7:0] sense_cycles(input logic [1:0] code);
        unique case (code)
            2'h0: sense_cycles = 8'(`CYC_CEIL(`SENSE_T0_NS));
            2'h1: sense_cycles = 8'(`CYC_CEIL(`SENSE_T1_NS));
            2'h2: sense_cycles = 8'(`CYC_CEIL(`SENSE_T2_NS));
            2'h3: sense_cycles = 8'(`CYC_CEIL(`SENSE_T3_NS));
        endcase
    endfunction

    // gain code to V/V, same for each amplifier
    function automatic logic [6:0] gain_vv(input logic [1:0] code);
        unique case (code)
            2'h0: gain_vv = `GAIN0_VV;
            2'h1: gain_vv = `GAIN1_VV;
            2'h2: gain_vv = `GAIN2_VV;
            2'h3: gain_vv = `GAIN3_VV;
        endcase
    endfunction

    // ======================================================
    // protection and watchdog decode
    always_ff @(posedge SYS_CLK) begin
        OVERHEAT_SHUTDOWN_ENABLE <= op_reg[`OP_OVERHEAT_BIT];
        SUPPLY_LOW2_FAULT_DISABLE <= op_reg[`OP_SUPPLY2_BIT];
        DRIVER_FAULT_DISABLE <= op_reg[`OP_DRIVER_BIT];
        AMP_OUTPUT_CLAMP_ENABLE <= op_reg[`OP_CLAMP_BIT];
        SHUNT_OVERCURRENT_DISABLE <= op_reg[`OP_SHUNT_BIT];
        WATCHDOG_ENABLE <= op_reg[`OP_WATCHDOG_ENABLE_BIT];
        PUMP_LOW_THRESHOLD_SELECT <= op_reg[`OP_PUMP_BIT];
        unique case (op_reg[`OP_WD_HI:`OP_WD_LO])
            2'h0: WATCHDOG_PERIOD_CYCLES <= `WD_CNT_W'(WD_PERIOD0_CYCLES);
            2'h1: WATCHDOG_PERIOD_CYCLES <= `WD_CNT_W'(WD_PERIOD1_CYCLES);
            2'h2: WATCHDOG_PERIOD_CYCLES <= `WD_CNT_W'(WD_PERIOD2_CYCLES);
            2'h3: WATCHDOG_PERIOD_CYCLES <= `WD_CNT_W'(WD_PERIOD3_CYCLES);
        endcase
    end

    // ======================================================
    // current amplifier decode
    always_ff @(posedge SYS_CLK) begin
        AMP_OFFSET_CALIBRATE <= amp_reg[`AMP_CAL_HI:`AMP_CAL_LO];
        unique case (amp_reg[`AMP_BLANK_HI:`AMP_BLANK_LO])
            2'h0: AMP_BLANK_CYCLES <= 8'(`CYC_CEIL(`AMPB_T0_NS));
            2'h1: AMP_BLANK_CYCLES <= 8'(`CYC_CEIL(`AMPB_T1_NS));
            2'h2: AMP_BLANK_CYCLES <= 8'(`CYC_CEIL(`AMPB_T2_NS));
            2'h3: AMP_BLANK_CYCLES <= 8'(`CYC_CEIL(`AMPB_T3_NS));
        endcase
        AMP1_GAIN_VV <= gain_vv(amp_reg[`AMP1_GAIN_HI:`AMP1_GAIN_LO]);
        AMP2_GAIN_VV <= gain_vv(amp_reg[`AMP2_GAIN_HI:`AMP2_GAIN_LO]);
        AMP3_GAIN_VV <= gain_vv(amp_reg[`AMP3_GAIN_HI:`AMP3_GAIN_LO]);
    end

    // ======================================================
    // regulator decode; reserved scale codes show zero
    always_ff @(posedge SYS_CLK) begin
        unique case (regu_reg[`REG_SCALE_HI:`REG_SCALE_LO])
            2'h1: REF_SCALE_K <= `SCALE_K2;
            2'h2: REF_SCALE_K <= `SCALE_K4;
            default: REF_SCALE_K <= `SCALE_RESERVED_BITS;
        endcase
        REGULATOR_LOW_FAULT_DISABLE <= regu_reg[`REG_UVDIS_BIT];
        unique case (regu_reg[`REG_SET_HI:`REG_SET_LO])
            2'h0: REGULATOR_LOW_SETPOINT_PCT <= `SET_PCT0;
            2'h1: REGULATOR_LOW_SETPOINT_PCT <= `SET_PCT1;
            default: REGULATOR_LOW_SETPOINT_PCT <= `SET_PCT2;
        endcase
    end

    // ======================================================
    // checks
    sequence op_write_s;
        wr_op && !REG_WR_DATA[`OP_SLEEP_BIT];
    endsequence

    sequence sleep_now_s;
        sleep_entry && (regu_reg[`REG_DLY_HI:`REG_DLY_LO] == 2'h0);
    endsequence

    freewheel_gate_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        1'b1 |=> ACTIVE_FREEWHEEL == $past(fw_cause))
        else $error("freewheel output does not follow mode and bit");

    mode_alias_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        gate_reg[`GATE_MODE_HI:`GATE_MODE_LO] == 2'h3 |=> INPUT_MODE == gdc_pkg::MODE_SIX)
        else $error("mode code 11 not treated as six inputs");

    dead_time_max_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        gate_reg[`GATE_DT_HI:`GATE_DT_LO] == 3'h7 |=> DEAD_TIME_CYCLES == 8'h84)
        else $error("longest dead time count wrong");

    filter_max_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        gate_reg[`GATE_FILT_HI:`GATE_FILT_LO] == 2'h3 |=> DRAIN_SENSE_FILTER_CYCLES == 8'haf)
        else $error("longest filter count wrong");

    op_bits_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        op_write_s ##1 !sleep_entry |=> WATCHDOG_ENABLE == $past(REG_WR_DATA[`OP_WATCHDOG_ENABLE_BIT], 2)
            && OVERHEAT_SHUTDOWN_ENABLE == $past(REG_WR_DATA[`OP_OVERHEAT_BIT], 2))
        else $error("operation bits not reaching outputs");

    fault_pulse_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        wr_op && REG_WR_DATA[`OP_CLEAR_BIT] |=> FAULT_CLEAR ##1 !FAULT_CLEAR || $past(wr_op))
        else $error("fault clear pulse wrong");

    sleep_default_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        sleep_entry |=> SLEEP_ACTIVE && op_reg == `OP_DEFAULT && gate_reg == `GATE_DEFAULT)
        else $error("sleep entry did not restore defaults");

    sleep_zero_delay_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        sleep_now_s ##1 !wr_op |=> REGULATOR_OFF)
        else $error("regulator not off after zero delay");

    hold_regs_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        !REG_WR_EN |=> $stable(op_reg) && $stable(amp_reg) && $stable(regu_reg))
        else $error("register changed without a write");

    wd_period_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        op_reg[`OP_WD_HI:`OP_WD_LO] == 2'h1 |=>
            WATCHDOG_PERIOD_CYCLES == `WD_CNT_W'(WD_PERIOD1_CYCLES))
        else $error("watchdog period wrong");

    scale_k_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        regu_reg[`REG_SCALE_HI:`REG_SCALE_LO] == 2'h2 |=> REF_SCALE_K == `SCALE_K4)
        else $error("scale k wrong");

endmodule

`default_nettype wire

// ===== hdl/gdc_params.svh
/*
 * Constants of the gate driver control register bank: register addresses,
 * field positions, reset values and timing figures with their cycle counts.
 * Assumes a 25 MHz system clock; included by bare name from the design files.
 */
`ifndef GDC_PARAMS_SVH
`define GDC_PARAMS_SVH

// ======================================================
// clock
`define CLK_PERIOD_NS 40
`define CLK_MHZ 25
`define CYC_CEIL(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ======================================================
// register addresses and widths
`define ADDR_W 4
`define DATA_W 11
`define ADDR_GATE 4'h7
`define ADDR_OP 4'h9
`define ADDR_AMP 4'ha
`define ADDR_REG 4'hb

// ======================================================
// reset values
`define GATE_DEFAULT 11'h216
`define OP_DEFAULT 11'h020
`define AMP_DEFAULT 11'h000
`define REG_DEFAULT 11'h10a

// ======================================================
// commutation timing fields
`define GATE_FW_BIT 9
`define GATE_MODE_HI 8
`define GATE_MODE_LO 7
`define GATE_DT_HI 6
`define GATE_DT_LO 4
`define GATE_BLANK_HI 3
`define GATE_BLANK_LO 2
`define GATE_FILT_HI 1
`define GATE_FILT_LO 0

// ======================================================
// operation fields
`define OP_OVERHEAT_BIT 10
`define OP_SUPPLY2_BIT 9
`define OP_DRIVER_BIT 8
`define OP_CLAMP_BIT 7
`define OP_WD_HI 6
`define OP_WD_LO 5
`define OP_SHUNT_BIT 4
`define OP_WATCHDOG_ENABLE_BIT 3
`define OP_SLEEP_BIT 2
`define OP_CLEAR_BIT 1
`define OP_PUMP_BIT 0

// ======================================================
// current amplifier fields
`define AMP_CAL_HI 10
`define AMP_CAL_LO 8
`define AMP_BLANK_HI 7
`define AMP_BLANK_LO 6
`define AMP3_GAIN_HI 5
`define AMP3_GAIN_LO 4
`define AMP2_GAIN_HI 3
`define AMP2_GAIN_LO 2
`define AMP1_GAIN_HI 1
`define AMP1_GAIN_LO 0

// ======================================================
// regulator fields
`define REG_SCALE_HI 9
`define REG_SCALE_LO 8
`define REG_DLY_HI 4
`define REG_DLY_LO 3
`define REG_UVDIS_BIT 2
`define REG_SET_HI 1
`define REG_SET_LO 0

// ======================================================
// dead time figures in ns
`define DT0_NS 35
`define DT1_NS 52
`define DT2_NS 88
`define DT3_NS 440
`define DT4_NS 880
`define DT5_NS 1760
`define DT6_NS 3520
`define DT7_NS 5280

// drain sense blanking and filter figures in ns
`define SENSE_T0_NS 0
`define SENSE_T1_NS 1750
`define SENSE_T2_NS 3500
`define SENSE_T3_NS 7000

// amplifier blanking figures in ns
`define AMPB_T0_NS 0
`define AMPB_T1_NS 500
`define AMPB_T2_NS 2500
`define AMPB_T3_NS 10000

// regulator power-down delay figures
`define SLP_D0_NS 0
`define SLP_D1_NS 10000
`define SLP_D2_NS 50000
`define SLP_D3_US 1000
`define SLP_CNT_W 15

// watchdog periods in ms
`define WD_P0_MS 10
`define WD_P1_MS 20
`define WD_P2_MS 50
`define WD_P3_MS 100
`define WD_CNT_W 22

// gain, scale and set point figures
`define GAIN0_VV 7'h0a
`define GAIN1_VV 7'h14
`define GAIN2_VV 7'h28
`define GAIN3_VV 7'h50
`define SCALE_K2 3'h2
`define SCALE_K4 3'h4
`define SCALE_RESERVED_BITS 3'h0
`define SET_PCT0 7'h5a
`define SET_PCT1 7'h50
`define SET_PCT2 7'h46

`endif

// ===== hdl/gdc_pkg.sv
/*
 * Types of the gate driver control register bank: input mode and the
 * sleep sequencer state. Assumes nothing of its surroundings.
 */
package gdc_pkg;

    // ======================================================
    // commutation input mode as seen by the gate drivers
    typedef enum logic [1:0] {
        MODE_SIX = 2'h0,
        MODE_THREE = 2'h1,
        MODE_SINGLE = 2'h2
    } input_mode_t;

    // ======================================================
    // sleep sequencer, one-hot
    typedef enum logic [2:0] {
        ST_AWAKE = 3'h1,
        ST_DELAY = 3'h2,
        ST_OFF = 3'h4
    } sleep_state_t;

endpackage

// ===== hdl/config_field_reg.sv
/*
 * One read/write configuration register with a reset value that is
 * restored on reset and on a default-load request.
 * Assumes a synchronous active-high reset on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

module config_field_reg #(
    parameter int WIDTH = 11,
    parameter logic [WIDTH-1:0] DEFAULT = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic load_default,
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wr_data,
    // stored value
    output logic [WIDTH-1:0] value
);

    // ======================================================
    // default load beats a write in the same cycle
    always_ff @(posedge clk) begin
        if (rst || load_default) begin
            value <= DEFAULT;
        end else if (wr_en) begin
            value <= wr_data;
        end
    end

endmodule

`default_nettype wire

// ===== verif/host_model.sv
/*
 * Host side of the register access port: one-cycle write and read strobes.
 * Assumes the bank samples on the rising edge and answers a read one cycle later.
 */
`timescale 1ns/100ps
`default_nettype none

module host_model (
    // clock and read answer
    input wire logic clk,
    input wire logic rd_valid,
    input wire logic [10:0] rd_data,
    // access strobes
    output logic wr_en,
    output logic rd_en,
    output logic [3:0] addr,
    output logic [10:0] wr_data
);
    // ======================================================
    // access tasks
    logic late = 1'b0;
    // idle strobes from time zero
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 4'h0;
        wr_data = 11'h000;
    end
    // write held through its taking edge
    task automatic wr(input logic [3:0] a, input logic [10:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    // read, answer awaited under a bound
    task automatic rd(input logic [3:0] a, output logic [10:0] d);
        int n;
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        n = 0;
        #1;
        while (rd_valid !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        late = late | (n == 4);
        d = rd_data;
    endtask
endmodule

`default_nettype wire

// ===== verif/gate_driver_control_regs_tb_top.sv
/*
 * Self-checking bench of the control register bank: defaults, decodes, sleep.
 * Assumes the host model drives the access port and a small count for watchdog period 3.
 */
`timescale 1ns/100ps
`default_nettype none

module gate_driver_control_regs_tb_top;
    // ======================================================
    // signals and expectation tables
    logic clk, rst, we, re, fw, ot, s2, dv, sh, pu, wde, fc, cl, rld, slp, rof, rv;
    logic [1:0] md;
    logic [2:0] cal, k;
    logic [3:0] ad;
    logic [6:0] g1, g2, g3, sp;
    logic [7:0] dt, bl, fl, ab;
    logic [10:0] wd, rdd, v;
    logic [21:0] wdp;
    logic [7:0] dtx [8] = '{8'h01, 8'h02, 8'h03, 8'h0b, 8'h16, 8'h2c, 8'h58, 8'h84};
    logic [6:0] gx [4] = '{7'h0a, 7'h14, 7'h28, 7'h50};
    logic [7:0] abx [4] = '{8'h00, 8'h0d, 8'h3f, 8'hfa};
    logic [2:0] kx [4] = '{3'h0, 3'h2, 3'h4, 3'h0};
    logic [6:0] spx [4] = '{7'h5a, 7'h50, 7'h46, 7'h46};
    logic [7:0] sx [4] = '{8'h00, 8'h2c, 8'h58, 8'haf};
    int error_cnt = 0, n_tests = 0, i, c;

    host_model host (.clk(clk), .rd_valid(rv), .rd_data(rdd), .wr_en(we), .rd_en(re),
        .addr(ad), .wr_data(wd));
    gate_driver_control_regs #(.SLEEP_DELAY_LONG_CYCLES(20), .WD_PERIOD3_CYCLES(100)) dut (
        .SYS_CLK(clk), .RST(rst), .REG_WR_EN(we), .REG_RD_EN(re), .REG_ADDR(ad),
        .REG_WR_DATA(wd), .REG_RD_DATA(rdd), .REG_RD_VALID(rv), .ACTIVE_FREEWHEEL(fw),
        .INPUT_MODE(md), .DEAD_TIME_CYCLES(dt), .DRAIN_SENSE_BLANK_CYCLES(bl),
        .DRAIN_SENSE_FILTER_CYCLES(fl), .OVERHEAT_SHUTDOWN_ENABLE(ot),
        .SUPPLY_LOW2_FAULT_DISABLE(s2), .DRIVER_FAULT_DISABLE(dv),
        .SHUNT_OVERCURRENT_DISABLE(sh), .PUMP_LOW_THRESHOLD_SELECT(pu),
        .WATCHDOG_ENABLE(wde), .WATCHDOG_PERIOD_CYCLES(wdp), .FAULT_CLEAR(fc),
        .AMP_OUTPUT_CLAMP_ENABLE(cl), .AMP_OFFSET_CALIBRATE(cal), .AMP_BLANK_CYCLES(ab),
        .AMP1_GAIN_VV(g1), .AMP2_GAIN_VV(g2), .AMP3_GAIN_VV(g3), .REF_SCALE_K(k),
        .REGULATOR_LOW_FAULT_DISABLE(rld), .REGULATOR_LOW_SETPOINT_PCT(sp),
        .SLEEP_ACTIVE(slp), .REGULATOR_OFF(rof));

    // compare, count and report
    task automatic chk(input logic [21:0] g, input logic [21:0] e);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // read and compare; a lost answer ends the run
    task automatic rdc(input logic [3:0] a, input logic [10:0] e);
        host.rd(a, v);
        if (host.late) begin
            error_cnt++;
            test_done;
        end else begin
            chk(v, e);
        end
    endtask
    // let register and decode stages land
    task automatic st;
        repeat (2) @(posedge clk);
        #1;
    endtask

    // 40 ns clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // main sequence
    initial begin
        rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({dt, bl, fl}, {8'h02, 8'h2c, 8'h58});
        chk({ot, wde}, 2'h0);
        rdc(4'h7, 11'h216);
        rdc(4'h9, 11'h020);
        rdc(4'ha, 11'h000);
        rdc(4'hb, 11'h10a);
        rdc(4'h3, 11'h000);
        for (i = 0; i < 8; i++) begin
            host.wr(4'h7, {1'h0, i[2], i[1:0], i[2:0], i[1:0], i[1:0]});
            st;
            chk(dt, dtx[i]);
            chk(md, (i[1:0] == 2'h3) ? 2'h0 : i[1:0]);
            chk(fw, i[2] && (i[1:0] == 2'h2));
            chk({bl, fl}, {sx[i[1:0]], sx[i[1:0]]});
        end
        for (i = 0; i < 4; i++) begin
            host.wr(4'ha, {i[1:0], i[0], i[1:0], i[1:0], i[1:0], i[1:0]});
            host.wr(4'hb, {1'h0, i[1:0], 5'h00, i[0], i[1:0]});
            st;
            chk({g1, g2, g3}, {3{gx[i]}});
            chk({cal, ab}, {i[1:0], i[0], abx[i]});
            chk({k, sp, rld}, {kx[i], spx[i], i[0]});
        end
        rdc(4'hb, 11'h307);
        host.wr(4'h9, 11'h7f9);
        st;
        chk({ot, s2, dv, cl, sh, wde, pu}, 7'h7f);
        chk(wdp, 22'h000064);
        rdc(4'h9, 11'h7f9);
        host.wr(4'h9, 11'h002);
        c = 0;
        for (i = 0; i < 3; i++) begin
            #1;
            c += int'(fc === 1'b1);
            @(posedge clk);
        end
        chk(22'(c), 22'h000001);
        rdc(4'h7, 11'h3ff);
        host.wr(4'h9, 11'h004);
        st;
        chk({slp, rof}, 2'h3);
        rdc(4'h9, 11'h020);
        rdc(4'hb, 11'h10a);
        host.wr(4'h9, 11'h000);
        st;
        chk({slp, rof}, 2'h0);
        // default delay code: 250 cycles of 40 ns, one more for the cycle at a count of zero
        host.wr(4'h9, 11'h004);
        c = 0;
        while (rof !== 1'b1 && c < 400) begin
            @(posedge clk);
            #1;
            c++;
        end
        chk(22'(c), 22'h0000fb);
        test_done;
    end
endmodule

`default_nettype wire
